//--- tb/motion_ctl_model.sv
// motion controller model driving step, sense, size select and disable pins
`timescale 1ns/10ps
`default_nettype none
module motion_ctl_model
  import stepper_pkg::*;
(
  // clock
  input wire logic hclk,
  // pins to the sequencer
  output var ctl_pins_t ctl_pins
);
  initial begin
    ctl_pins = 4'b1100;
  end

  // sense and size settle well ahead of any fall
  task automatic move_levels(input logic dir, input logic sel);
    @(posedge hclk);
    ctl_pins.rotation_sense <= dir;
    ctl_pins.step_size_select <= sel;
    repeat (4) @(posedge hclk);
  endtask

  // one falling step edge, levels held through it
  task automatic step_once(input logic dir, input logic sel);
    move_levels(dir, sel);
    ctl_pins.step <= 1'b0;
    repeat (4) @(posedge hclk);
    ctl_pins.step <= 1'b1;
    repeat (4) @(posedge hclk);
  endtask

  task automatic set_disable(input logic v);
    @(posedge hclk);
    ctl_pins.output_disable <= v;
    repeat (4) @(posedge hclk);
  endtask
endmodule // motion_ctl_model
`default_nettype wire

//--- tb/stepper_phase_sequencer_tb.sv
// self-checking bench for the step sequencer
`timescale 1ns/10ps
`default_nettype none
`include "stepper_defs.svh"
module stepper_phase_sequencer_tb
  import stepper_pkg::*;
;
  localparam int PC = 20;
  localparam logic [3:0] PAT [8] = '{4'ha, 4'he, 4'h6, 4'h7, 4'h5, 4'hd, 4'h9, 4'hb};
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  ctl_pins_t ctl_pins;
  phase_t phase_lvl, phase_oe;
  half_t half_lvl, half_oe;
  boost_t boost_lvl, boost_oe;
  int miscompares, check_count, run, last_run, plen;
  logic [2:0] exp_idx;
  logic exp_dis, hold_on;

  stepper_phase_sequencer #(.PULSE_CYCLES(PC)) u_stepper_phase_sequencer (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ctl_pins(ctl_pins),
    .phase_lvl(phase_lvl), .phase_oe(phase_oe), .half_lvl(half_lvl),
    .half_oe(half_oe), .boost_lvl(boost_lvl), .boost_oe(boost_oe));
  motion_ctl_model u_motion_ctl_model (.hclk(hclk), .ctl_pins(ctl_pins));

  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  // length of the last boost pulse in cycles
  always @(posedge hclk) begin
    if (|boost_lvl) run <= run + 1;
    else begin
      if (run != 0) last_run <= run;
      run <= 0;
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic final_report();
    if (miscompares == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {20'h0, a};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    check("hresp", 32'(hresp), 32'h0);
  endtask

  task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(name, rd, exp);
  endtask

  function automatic logic [31:0] exp_stat(input logic [1:0] eb);
    logic [3:0] p;
    p = PAT[exp_idx];
    return {20'h0, exp_dis, exp_idx, eb, p[3:2] == 2'b11, p[1:0] == 2'b11, p};
  endfunction

  task automatic chk_pins();
    logic [31:0] s;
    logic [3:0] p_on;
    logic [1:0] h_on;
    s = exp_stat(2'h0);
    // invert at pin width so the cast pads with zeros
    p_on = ~s[3:0];
    h_on = ~s[5:4];
    check("phase_lvl", 32'(phase_lvl), 32'(s[3:0]));
    check("phase_oe", 32'(phase_oe), exp_dis ? 32'h0 : 32'(p_on));
    check("half_lvl", 32'(half_lvl), 32'(s[5:4]));
    check("half_oe", 32'(half_oe), exp_dis ? 32'h0 : 32'(h_on));
  endtask

  task automatic step_chk(input logic dir, input logic sel);
    logic [2:0] n;
    logic [3:0] a;
    logic [3:0] b;
    logic [1:0] eb;
    n = exp_idx + (dir ? 3'h1 : 3'h7);
    if (sel && !exp_idx[0]) n = n + (dir ? 3'h1 : 3'h7);
    a = PAT[exp_idx];
    b = PAT[n];
    eb = n[0] ? 2'h0 : {a[3:2] != b[3:2], a[1:0] != b[1:0]};
    u_motion_ctl_model.step_once(dir, sel);
    exp_idx = n;
    chk_pins();
    check("boost_lvl", 32'(boost_lvl), 32'(eb));
    check("boost_oe", 32'(boost_oe), 32'(eb));
    // step period kept above the pulse length
    repeat (plen + 8) @(posedge hclk);
    if (!hold_on) begin
      check("boost_off", 32'(boost_lvl), 32'h0);
      if (eb != 2'h0) check("pulse_len", last_run, plen);
    end
    rd_chk("status", `STATUS_OFFSET, exp_stat(hold_on ? eb : 2'h0));
  endtask

  task automatic do_reset(input int n);
    hresetn <= 1'b0;
    repeat (n) @(posedge hclk);
    hresetn <= 1'b1;
    exp_idx = 3'h0;
    plen = PC;
    repeat (5) @(posedge hclk);
    chk_pins();
    check("boost_rst", 32'(boost_lvl), 32'h0);
    rd_chk("ctrl", `CTRL_OFFSET, 32'h0);
    rd_chk("pulse_len", `PULSE_LEN_OFFSET, PC);
    bus(1'b1, `STATUS_OFFSET, 32'hffff_ffff);
    rd_chk("status", `STATUS_OFFSET, 32'h0000_000a);
    rd_chk("unmapped", 12'h00c, 32'h0);
  endtask

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    miscompares = 0;
    check_count = 0;
    run = 0;
    last_run = 0;
    exp_dis = 1'b0;
    hold_on = 1'b0;
    do_reset(10);
    // half steps round the cycle both ways
    repeat (8) step_chk(1'b1, 1'b0);
    repeat (8) step_chk(1'b0, 1'b0);
    // full steps from odd and even states
    step_chk(1'b1, 1'b0);
    step_chk(1'b1, 1'b1);
    step_chk(1'b1, 1'b1);
    step_chk(1'b0, 1'b1);
    step_chk(1'b0, 1'b0);
    step_chk(1'b0, 1'b1);
    // level changes without a step edge leave the state
    u_motion_ctl_model.move_levels(1'b0, 1'b1);
    u_motion_ctl_model.move_levels(1'b1, 1'b0);
    chk_pins();
    rd_chk("status", `STATUS_OFFSET, exp_stat(2'h0));
    // steps while outputs float
    u_motion_ctl_model.set_disable(1'b1);
    exp_dis = 1'b1;
    chk_pins();
    step_chk(1'b1, 1'b0);
    step_chk(1'b1, 1'b1);
    u_motion_ctl_model.set_disable(1'b0);
    exp_dis = 1'b0;
    chk_pins();
    // shorter pulse, then hold mode
    bus(1'b1, `PULSE_LEN_OFFSET, 32'h8);
    plen = 8;
    rd_chk("pulse_len", `PULSE_LEN_OFFSET, 32'h8);
    step_chk(1'b1, 1'b1);
    bus(1'b1, `CTRL_OFFSET, 32'h1);
    rd_chk("ctrl", `CTRL_OFFSET, 32'h1);
    hold_on = 1'b1;
    step_chk(1'b1, 1'b1);
    check("boost_hold", 32'(boost_lvl), 32'h2);
    hold_on = 1'b0;
    bus(1'b1, `CTRL_OFFSET, 32'h0);
    repeat (plen + 4) @(posedge hclk);
    check("boost_end", 32'(boost_lvl), 32'h0);
    do_reset(3);
    final_report();
  end

  initial begin
    repeat (20000) @(posedge hclk);
    miscompares++;
    final_report();
  end
endmodule // stepper_phase_sequencer_tb
`default_nettype wire

//--- verilog/boost_one_shot.sv
// retriggerable one-shot with an optional hold-on mode
`timescale 1ns/10ps
`default_nettype none
module boost_one_shot #(
  parameter int CW = 16
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // control
  input wire logic fire,
  input wire logic [CW-1:0] len,
  input wire logic hold,
  // pulse
  output logic active
);
  if (CW < 1) begin : g_bad_cw
    $error("one-shot counter width must be at least one");
  end

  logic active_ff, nxt_active;
  logic [CW-1:0] cnt_ff, nxt_cnt;

  always_comb begin
    nxt_active = active_ff;
    nxt_cnt = cnt_ff;
    if (fire) begin
      // zero length still gives one cycle
      nxt_active = 1'b1;
      nxt_cnt = (len == '0) ? CW'(1) : len;
    end else if (active_ff && !hold) begin
      if (cnt_ff <= CW'(1)) begin
        nxt_active = 1'b0;
        nxt_cnt = '0;
      end else begin
        nxt_cnt = cnt_ff - CW'(1);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      active_ff <= 1'b0;
      cnt_ff <= '0;
    end else begin
      active_ff <= nxt_active;
      cnt_ff <= nxt_cnt;
    end
  end

  assign active = active_ff;

  chk_hold_keeps_on: assert property (@(posedge hclk) disable iff (!hresetn)
    active_ff && hold |=> active_ff)
    else $error("one-shot ended while hold set");
  chk_pulse_ends: assert property (@(posedge hclk) disable iff (!hresetn)
    active_ff && !hold && !fire && cnt_ff == CW'(1) |=> !active_ff)
    else $error("one-shot overran its length");
endmodule // boost_one_shot
`default_nettype wire

//--- verilog/pin_sync.sv
// two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  if (WIDTH < 1) begin : g_bad_width
    $error("synchroniser width must be at least one");
  end

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= d;
      sync_ff <= meta_ff;
    end
  end

  assign q = sync_ff;
endmodule // pin_sync
`default_nettype wire

//--- verilog/stepper_defs.svh
// register offsets, field positions, reset values and timings in ns
`ifndef STEPPER_DEFS_SVH
`define STEPPER_DEFS_SVH

`define CTRL_OFFSET 12'h000
`define PULSE_LEN_OFFSET 12'h004
`define STATUS_OFFSET 12'h008

`define CTRL_HOLD_BIT 0
`define CTRL_RESET 32'h0000_0000

`define STATUS_PHASE_LSB 0
`define STATUS_HALF_LSB 4
`define STATUS_BOOST_LSB 6
`define STATUS_STATE_LSB 8
`define STATUS_DISABLE_BIT 11

`define POWER_UP_STATE 3'h0

`define CLOCK_PERIOD_NS 50
`define PULSE_ON_TIME_NS 325000

`endif

//--- verilog/stepper_phase_sequencer.sv
// step/direction sequencer for a two-phase stepper, with AHB-Lite registers
//
// Overview of operation
// - state changes only on falling step edge
// - rotation_sense picks forward or backward order
// - select low half steps, high full
// - sense and select sampled at step edge
// - phases pulled low in state order
// - output_disable floats phases and half indicators
// - steps while disabled still move state
// - half indicators pull low or float
// - boost drives high only while one-shot active
// - step into full state fires boost
// - one shared pulse length, step slower
// - hold mode keeps one-shot on indefinitely
// - reset enters 1010, indicators low
// - full mode always lands on full state
// - no boost entering half state
// - 0110 forward full goes 0101, second boost
`timescale 1ns/10ps
`default_nettype none
`include "stepper_defs.svh"
module stepper_phase_sequencer
  import stepper_pkg::*;
#(
  parameter int PULSE_CYCLES =
    (`PULSE_ON_TIME_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS,
  parameter int LEN_W = 16
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // motion controller pins
  input wire ctl_pins_t ctl_pins,
  // winding drive, level and enable per pin
  output var phase_t phase_lvl,
  output var phase_t phase_oe,
  output var half_t half_lvl,
  output var half_t half_oe,
  output var boost_t boost_lvl,
  output var boost_t boost_oe
);

  // refuse a reset length that the counter cannot hold
  if (LEN_W < 1 || LEN_W > 31 || PULSE_CYCLES < 1 ||
      PULSE_CYCLES >= (1 << LEN_W)) begin : g_bad_len
    $error("pulse length does not fit its counter");
  end

  localparam logic [LEN_W-1:0] PULSE_RESET = LEN_W'(PULSE_CYCLES);

  function automatic phase_t phase_of(input step_idx_t idx);
    // even entries are full steps, odd ones half steps
    unique case (idx)
      3'h0: phase_of = 4'b1010;
      3'h1: phase_of = 4'b1110;
      3'h2: phase_of = 4'b0110;
      3'h3: phase_of = 4'b0111;
      3'h4: phase_of = 4'b0101;
      3'h5: phase_of = 4'b1101;
      3'h6: phase_of = 4'b1001;
      3'h7: phase_of = 4'b1011;
    endcase
  endfunction

  // ---- pin synchronisation and edge detect
  ctl_pins_t pins_s;
  logic step_d_ff;
  logic step_fall;

  pin_sync #(.WIDTH(4)) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .d(ctl_pins),
    .q(pins_s)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      step_d_ff <= 1'b0;
    end else begin
      step_d_ff <= pins_s.step;
    end
  end

  assign step_fall = step_d_ff && !pins_s.step;

  // ---- registers
  logic ctrl_hold_ff, nxt_ctrl_hold;
  logic [LEN_W-1:0] pulse_len_ff, nxt_pulse_len;
  logic wr_pend_ff, nxt_wr_pend;
  logic [11:0] wr_addr_ff, nxt_wr_addr;
  logic [31:0] hrdata_ff, nxt_hrdata;
  logic addr_phase;
  logic [31:0] status_word;

  // ---- sequencing state
  step_idx_t state_ff, nxt_state;
  phase_t phase_lvl_ff, nxt_phase_lvl;
  phase_t phase_oe_ff, nxt_phase_oe;
  half_t half_lvl_ff, nxt_half_lvl;
  half_t half_oe_ff, nxt_half_oe;
  phase_t cur_ph, new_ph;
  boost_t fire;
  boost_t active;

  always_comb begin
    nxt_state = state_ff;
    if (step_fall) begin
      // full mode from a half state only goes one to reach full
      if (pins_s.rotation_sense) begin
        if (pins_s.step_size_select && !state_ff[0]) begin
          nxt_state = state_ff + 3'h2;
        end else begin
          nxt_state = state_ff + 3'h1;
        end
      end else begin
        if (pins_s.step_size_select && !state_ff[0]) begin
          nxt_state = state_ff - 3'h2;
        end else begin
          nxt_state = state_ff - 3'h1;
        end
      end
    end
    cur_ph = phase_of(state_ff);
    new_ph = phase_of(nxt_state);
    nxt_phase_lvl = new_ph;
    // disable only masks the drivers, state keeps moving
    nxt_phase_oe = pins_s.output_disable ? 4'b0000 : ~new_ph;
    nxt_half_lvl.half_a = new_ph.phase_a_first && new_ph.phase_a_second;
    nxt_half_lvl.half_b = new_ph.phase_b_first && new_ph.phase_b_second;
    nxt_half_oe = pins_s.output_disable ? 2'b00 : ~nxt_half_lvl;
    // boost the winding that changes when a full state is entered
    fire.boost_pulse_first = step_fall && !nxt_state[0] &&
      ({new_ph.phase_a_first, new_ph.phase_a_second} !=
       {cur_ph.phase_a_first, cur_ph.phase_a_second});
    fire.boost_pulse_second = step_fall && !nxt_state[0] &&
      ({new_ph.phase_b_first, new_ph.phase_b_second} !=
       {cur_ph.phase_b_first, cur_ph.phase_b_second});
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= `POWER_UP_STATE;
      phase_lvl_ff <= 4'b1010;
      phase_oe_ff <= 4'b0000;
      half_lvl_ff <= 2'b00;
      half_oe_ff <= 2'b00;
    end else begin
      state_ff <= nxt_state;
      phase_lvl_ff <= nxt_phase_lvl;
      phase_oe_ff <= nxt_phase_oe;
      half_lvl_ff <= nxt_half_lvl;
      half_oe_ff <= nxt_half_oe;
    end
  end

  // one shared length for both one-shots
  boost_one_shot #(.CW(LEN_W)) u_shot_first (
    .hclk(hclk),
    .hresetn(hresetn),
    .fire(fire.boost_pulse_first),
    .len(pulse_len_ff),
    .hold(ctrl_hold_ff),
    .active(active.boost_pulse_first)
  );

  boost_one_shot #(.CW(LEN_W)) u_shot_second (
    .hclk(hclk),
    .hresetn(hresetn),
    .fire(fire.boost_pulse_second),
    .len(pulse_len_ff),
    .hold(ctrl_hold_ff),
    .active(active.boost_pulse_second)
  );

  assign phase_lvl = phase_lvl_ff;
  assign phase_oe = phase_oe_ff;
  assign half_lvl = half_lvl_ff;
  assign half_oe = half_oe_ff;
  assign boost_lvl = active;
  assign boost_oe = active;

  // ---- AHB-Lite slave, zero wait states
  assign addr_phase = hsel && htrans[1] && hready;

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`STATUS_PHASE_LSB +: 4] = phase_lvl_ff;
    status_word[`STATUS_HALF_LSB +: 2] = half_lvl_ff;
    status_word[`STATUS_BOOST_LSB +: 2] = active;
    status_word[`STATUS_STATE_LSB +: 3] = state_ff;
    status_word[`STATUS_DISABLE_BIT] = pins_s.output_disable;
  end

  always_comb begin
    nxt_ctrl_hold = ctrl_hold_ff;
    nxt_pulse_len = pulse_len_ff;
    if (wr_pend_ff) begin
      if (wr_addr_ff == `CTRL_OFFSET) begin
        nxt_ctrl_hold = hwdata[`CTRL_HOLD_BIT];
      end
      if (wr_addr_ff == `PULSE_LEN_OFFSET) begin
        nxt_pulse_len = hwdata[LEN_W-1:0];
      end
    end
    nxt_wr_pend = addr_phase && hwrite;
    nxt_wr_addr = addr_phase ? haddr[11:0] : wr_addr_ff;
    // read data built from next values so a write just ahead shows
    nxt_hrdata = 32'h0000_0000;
    if (addr_phase && !hwrite && haddr[31:12] == 20'h00000) begin
      if (haddr[11:0] == `CTRL_OFFSET) begin
        nxt_hrdata[`CTRL_HOLD_BIT] = nxt_ctrl_hold;
      end else if (haddr[11:0] == `PULSE_LEN_OFFSET) begin
        nxt_hrdata[LEN_W-1:0] = nxt_pulse_len;
      end else if (haddr[11:0] == `STATUS_OFFSET) begin
        nxt_hrdata = status_word;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_hold_ff <= 1'b0;
      pulse_len_ff <= PULSE_RESET;
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 12'h000;
      hrdata_ff <= 32'h0000_0000;
    end else begin
      ctrl_hold_ff <= nxt_ctrl_hold;
      pulse_len_ff <= nxt_pulse_len;
      wr_pend_ff <= nxt_wr_pend;
      wr_addr_ff <= nxt_wr_addr;
      hrdata_ff <= nxt_hrdata;
    end
  end

  logic hreadyout_ff;
  logic hresp_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
    end else begin
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
    end
  end

  assign hrdata = hrdata_ff;
  assign hreadyout = hreadyout_ff;
  assign hresp = hresp_ff;

  // ---- checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence fwd_full_from_2;
    step_fall && pins_s.rotation_sense && pins_s.step_size_select && state_ff == 3'h2;
  endsequence

  chk_state_only_edge: assert property (
    !step_fall |=> state_ff == $past(state_ff))
    else $error("state moved without a step edge");
  chk_dir_forward: assert property (
    step_fall && pins_s.rotation_sense && !pins_s.step_size_select
    |=> state_ff == $past(state_ff) + 3'h1)
    else $error("forward half step wrong");
  chk_dir_backward: assert property (
    step_fall && !pins_s.rotation_sense && !pins_s.step_size_select
    |=> state_ff == $past(state_ff) - 3'h1)
    else $error("backward half step wrong");
  chk_full_lands: assert property (
    step_fall && pins_s.step_size_select |=> !state_ff[0])
    else $error("full step landed on half state");
  chk_phase_match: assert property (
    phase_lvl_ff == phase_of(state_ff))
    else $error("phase pins do not match state");
  chk_disable_float: assert property (
    pins_s.output_disable |=> phase_oe_ff == 4'b0000 && half_oe_ff == 2'b00)
    else $error("outputs driven while disabled");
  chk_disabled_steps: assert property (
    pins_s.output_disable && step_fall |=> state_ff != $past(state_ff))
    else $error("step lost while disabled");
  chk_power_up: assert property (
    state_ff == `POWER_UP_STATE |-> phase_lvl_ff == 4'b1010 && half_lvl_ff == 2'b00)
    else $error("power-up state pattern wrong");
  chk_no_half_boost: assert property (
    step_fall ##1 state_ff[0] |-> !$rose(active.boost_pulse_first)
      && !$rose(active.boost_pulse_second))
    else $error("boost fired entering half state");
  chk_forward_0110: assert property (
    fwd_full_from_2 |=> state_ff == 3'h4 && active.boost_pulse_second)
    else $error("0110 forward full step wrong");
  chk_edge_sync: assert property (
    step_fall |-> !$past(ctl_pins.step, 2) && $past(ctl_pins.step, 3))
    else $error("step edge not from synchronised pin");

endmodule // stepper_phase_sequencer
`default_nettype wire

//--- verilog/stepper_pkg.sv
// types shared by the step sequencer and its helpers
package stepper_pkg;

  typedef logic [2:0] step_idx_t;

  // level 1 means off, 0 means pulled low
  typedef struct packed {
    logic phase_a_first;
    logic phase_a_second;
    logic phase_b_first;
    logic phase_b_second;
  } phase_t;

  typedef struct packed {
    logic half_a;
    logic half_b;
  } half_t;

  typedef struct packed {
    logic boost_pulse_first;
    logic boost_pulse_second;
  } boost_t;

  typedef struct packed {
    logic step;
    logic rotation_sense;
    logic step_size_select;
    logic output_disable;
  } ctl_pins_t;

endpackage
